// >>> hdl/kms_key_matrix_scanner.sv
// Purpose: keypad matrix scanner with per-key debounce
// Assumes: one clock, rows from pins, ahb-lite slave, one wait state on reads
// Notes:   keys stored 32 per word over three words
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module kms_key_matrix_scanner
   import kms_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   // clock and reset
   input  wire logic                hclk,
   input  wire logic                hresetn,
   // ahb-lite slave
   input  wire logic                hsel,
   input  wire logic [7:0]          haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic                hready,
   input  wire logic [31:0]         hwdata,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   // matrix pins
   input  wire logic [NUM_ROWS-1:0] key_row_line,
   output logic      [NUM_COLS-1:0] key_column_drive,
   output logic      [NUM_COLS-1:0] key_column_wires,
   // system
   output logic                     secondary_ext_irq,
   output logic                     wake_req,
   output logic                     keypad_reset_req
);
   // ************************************************
   // row synchroniser
   // ************************************************
   logic [NUM_ROWS-1:0] row_s1_r;
   logic [NUM_ROWS-1:0] row_s2_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_s1_r <= '1;
         row_s2_r <= '1;
      end else begin
         row_s1_r <= key_row_line;
         row_s2_r <= row_s1_r;
      end
   end

   // ************************************************
   // registers
   // ************************************************
   logic [4:0]          ctrl_r;
   logic [15:0]         timing_r;
   logic [ST_W-1:0]     status_r;
   logic [ST_W-1:0]     enable_r;
   logic                wr_pend_r;
   logic [7:0]          wr_addr_r;
   logic                rd_pend_r;
   logic [7:0]          rd_addr_r;
   logic [NUM_KEYS-1:0] key_state_r;
   logic [ST_W-1:0]     ev_set;

   // one word match, shared by the write and the read decode
   function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // seven bits, so even a fully closed matrix reads back right
   function automatic logic [6:0] popcount(input logic [NUM_KEYS-1:0] v);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 0; i < NUM_KEYS; i++) begin
         c = c + {6'h00, v[i]};
      end
      return c;
   endfunction

   // ************************************************
   // address decode
   // ************************************************
   wire       a_valid    = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
   wire       wr_ctrl    = wr_pend_r && hits(wr_addr_r, OFS_CTRL);
   wire       wr_timing  = wr_pend_r && hits(wr_addr_r, OFS_TIMING);
   wire       wr_clear   = wr_pend_r && hits(wr_addr_r, OFS_CLEAR);
   wire       wr_enable  = wr_pend_r && hits(wr_addr_r, OFS_ENABLE);
   wire       rd_ctrl    = hits(rd_addr_r, OFS_CTRL);
   wire       rd_timing  = hits(rd_addr_r, OFS_TIMING);
   wire       rd_status  = hits(rd_addr_r, OFS_STATUS);
   wire       rd_enable  = hits(rd_addr_r, OFS_ENABLE);
   wire       rd_count   = hits(rd_addr_r, OFS_COUNT);
   wire [1:0] key_word   = rd_addr_r[3:2];
   wire       rd_keys    = rd_addr_r[7:4] == OFS_KEYS0[7:4] && key_word != 2'h3;
   wire [7:0] glitch_lim = timing_r[TIM_GLITCH_LSB +: 8];
   wire [7:0] minpr_lim  = timing_r[TIM_MINPR_LSB +: 8];
   wire       scan_on    = ctrl_r[CTRL_SCAN];

   // ************************************************
   // read data select
   // ************************************************
   wire [NUM_KEYS+31:0] keys_pad = {32'h0000_0000, key_state_r};
   wire [31:0]          rd_mux   =
      rd_ctrl   ? {27'h000_0000, ctrl_r} :
      rd_timing ? {16'h0000, timing_r} :
      rd_status ? {29'h000_0000, status_r} :
      rd_enable ? {29'h000_0000, enable_r} :
      rd_count  ? {25'h00_0000, popcount(key_state_r)} :
      rd_keys   ? keys_pad[{key_word, 5'h00} +: 32] : 32'h0000_0000;

   // ************************************************
   // bus pipeline
   // ************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= a_valid && hwrite;
         if (a_valid)
            wr_addr_r <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= 8'h00;
      end else begin
         rd_pend_r <= a_valid && !hwrite;
         if (a_valid)
            rd_addr_r <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (rd_pend_r)
         hrdata <= rd_mux;
   end

   // read data registered one cycle late, so reads insert one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= !(a_valid && !hwrite);
         hresp     <= 1'b0;
      end
   end

   // ************************************************
   // control, status and enable registers
   // ************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ctrl_r <= CTRL_RESET;
      else if (wr_ctrl)
         ctrl_r <= hwdata[4:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         timing_r <= TIMING_RESET;
      else if (wr_timing)
         timing_r <= hwdata[15:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         enable_r <= '0;
      else if (wr_enable)
         enable_r <= hwdata[ST_W-1:0];
   end

   // set beats clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         status_r <= '0;
      else
         status_r <= (status_r & ~(wr_clear ? hwdata[ST_W-1:0] : '0)) | ev_set;
   end

   // ************************************************
   // 2 ms tick
   // ************************************************
   logic [$clog2(TICK_CYC)-1:0] tick_cnt_r;
   logic                        tick_r;
   wire                         tick_hit = tick_cnt_r == ($clog2(TICK_CYC))'(TICK_CYC - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else begin
         tick_r     <= tick_hit;
         tick_cnt_r <= tick_hit ? '0 : tick_cnt_r + 1'b1;
      end
   end

   // ************************************************
   // column walk
   // ************************************************
   kms_scan_type                sc_r;
   logic [$clog2(NUM_COLS)-1:0] col_r;
   logic [7:0]                  set_cnt_r;
   logic                        tick_pend_r;
   logic                        tick_frame_r;
   wire last_col   = col_r == ($clog2(NUM_COLS))'(NUM_COLS - 1);
   wire settle_end = set_cnt_r == 8'(SETTLE_CYCLES - 1);
   wire frame_end  = sc_r == SC_SAMPLE && last_col;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         set_cnt_r <= 8'h00;
      else if (sc_r == SC_DRIVE)
         set_cnt_r <= set_cnt_r + 8'h01;
      else
         set_cnt_r <= 8'h00;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sc_r  <= SC_GAP;
         col_r <= '0;
      end else begin
         case (sc_r)
            SC_DRIVE: begin
               if (settle_end)
                  sc_r <= SC_SAMPLE;
            end
            SC_SAMPLE: begin
               sc_r <= SC_GAP;
            end
            SC_GAP: begin
               if (scan_on) begin
                  sc_r  <= SC_DRIVE;
                  col_r <= last_col ? '0 : col_r + 1'b1;
               end
            end
            default: sc_r <= SC_GAP;
         endcase
      end
   end

   // a tick counts from the next whole frame on, so every key sees it once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_pend_r  <= 1'b0;
         tick_frame_r <= 1'b0;
      end else if (frame_end) begin
         tick_pend_r  <= 1'b0;
         tick_frame_r <= tick_pend_r || tick_r;
      end else if (tick_r) begin
         tick_pend_r  <= 1'b1;
      end
   end

   // column released in gap so only one wire is ever low
   wire [NUM_COLS-1:0] drive_nxt = (sc_r != SC_GAP && scan_on) ?
                                   NUM_COLS'(1) << col_r : '0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_column_drive <= '0;
         key_column_wires <= '1;
      end else begin
         key_column_drive <= drive_nxt;
         key_column_wires <= ~drive_nxt;
      end
   end

   // ************************************************
   // per-key debounce
   // ************************************************
   // raw press: a low row (pulled up when open) while column is low
   wire sample_now = sc_r == SC_SAMPLE;
   wire use_tick   = tick_frame_r;
   logic [7:0] db_cnt_r [NUM_KEYS];
   logic [NUM_KEYS-1:0] press_ev;
   logic [NUM_KEYS-1:0] rel_ev;
   // every key has its own state and counter, so any count of held keys works
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_state_r <= '0;
         for (int k = 0; k < NUM_KEYS; k++)
            db_cnt_r[k] <= 8'h00;
      end else begin
         for (int k = 0; k < NUM_KEYS; k++) begin
            if (sample_now && col_r == ($clog2(NUM_COLS))'(k / NUM_ROWS)) begin
               if (!row_s2_r[k % NUM_ROWS] == key_state_r[k]) begin
                  db_cnt_r[k] <= 8'h00; // bounce back: restart
               end else if (use_tick) begin
                  if (db_cnt_r[k] + 8'h01 >=
                      (key_state_r[k] ? glitch_lim : minpr_lim)) begin
                     key_state_r[k] <= !key_state_r[k];
                     db_cnt_r[k]    <= 8'h00;
                  end else begin
                     db_cnt_r[k] <= db_cnt_r[k] + 8'h01;
                  end
               end
            end
         end
      end
   end

   // ************************************************
   // key events
   // ************************************************
   logic [NUM_KEYS-1:0] key_prev_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         key_prev_r <= '0;
      else
         key_prev_r <= key_state_r;
   end
   assign press_ev = key_state_r & ~key_prev_r;
   assign rel_ev   = ~key_state_r & key_prev_r;
   assign ev_set[ST_PRESS]    = |press_ev;
   assign ev_set[ST_RELEASE]  = |rel_ev;
   assign ev_set[ST_ACTIVITY] = |press_ev | |rel_ev;

   // ************************************************
   // interrupt, wake and reset requests
   // ************************************************
   wire irq_nxt   = |(status_r & enable_r);
   wire any_low   = !(&row_s2_r);
   wire wake_nxt  = ctrl_r[CTRL_WAKE] && ctrl_r[CTRL_SLEEP] && (|press_ev || any_low);
   wire rst_nxt   = ctrl_r[CTRL_RSTEN] && ctrl_r[CTRL_PDOWN] && any_low;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         secondary_ext_irq <= 1'b0;
      else
         secondary_ext_irq <= irq_nxt;
   end

   // level for the power controller, held while the cause stands
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wake_req <= 1'b0;
      else
         wake_req <= wake_nxt;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         keypad_reset_req <= 1'b0;
      else
         keypad_reset_req <= rst_nxt;
   end
endmodule

// >>> hdl/kms_pkg.sv
// Purpose: constants for the key matrix scanner
// Assumes: 100 MHz hclk, AHB-Lite register access
// Notes:   register offsets are byte addresses
//
// Overview of operation
// - matrix of 8 rows by 11 columns
// - detects any number of held keys, up to all 88
// - rows pulled up, undriven row reads high
// - column driven low or released high
// - walking zero; low row marks key pressed
// - activity latched and interrupt raised
// - separate press and release notifications
// - glitches and bounce not reported
// - blackout and minimum press in 2 ms
// - wake enabled key press wakes chip
// - interrupt shares second external vector
// - power-down row low gives maskable reset
package kms_pkg;
   localparam int          NUM_ROWS      = 8;
   localparam int          NUM_COLS      = 11;
   localparam int          NUM_KEYS      = NUM_ROWS * NUM_COLS;
   localparam int          CLK_MHZ       = 100;
   localparam int          TICK_MS       = 2;
   localparam int          TICK_CYCLES   = TICK_MS * 1000 * CLK_MHZ;
   localparam int          SETTLE_NS     = 1000;
   localparam int          SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   // ************************************************
   // register map
   // ************************************************
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_TIMING    = 8'h04;
   localparam logic [7:0]  OFS_STATUS    = 8'h08;
   localparam logic [7:0]  OFS_CLEAR     = 8'h0C;
   localparam logic [7:0]  OFS_ENABLE    = 8'h10;
   localparam logic [7:0]  OFS_COUNT     = 8'h14;
   localparam logic [7:0]  OFS_KEYS0     = 8'h20;
   // ctrl fields
   localparam int          CTRL_SCAN     = 0;
   localparam int          CTRL_WAKE     = 1;
   localparam int          CTRL_RSTEN    = 2;
   localparam int          CTRL_PDOWN    = 3;
   localparam int          CTRL_SLEEP    = 4;
   localparam logic [4:0]  CTRL_RESET    = 5'h00;
   // timing fields: blackout [7:0], minimum press [15:8]
   localparam int          TIM_GLITCH_LSB = 0;
   localparam int          TIM_MINPR_LSB  = 8;
   localparam logic [15:0] TIMING_RESET  = 16'h0201;
   // status bits
   localparam int          ST_PRESS      = 0;
   localparam int          ST_RELEASE    = 1;
   localparam int          ST_ACTIVITY   = 2;
   localparam int          ST_W          = 3;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;
   typedef enum logic [2:0] {
      SC_DRIVE  = 3'b001,
      SC_SAMPLE = 3'b010,
      SC_GAP    = 3'b100
   } kms_scan_type;
endpackage

// >>> verif/kms_key_matrix_scanner_asserts.sv
// Purpose: port checks for the key matrix scanner
// Assumes: one clock, hresetn active low
// Notes:   bound into every scanner instance
`timescale 1ns/100ps
module kms_scanner_checker (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // pins
   input wire logic [7:0]  key_row_line,
   input wire logic [10:0] key_column_drive,
   input wire logic [10:0] key_column_wires,
   input wire logic        keypad_reset_req
);
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_one_col;
      $onehot0(key_column_drive);
   endproperty
   a_one_col: assert property (p_one_col) else $error("two columns driven");
   property p_wires;
      key_column_wires == ~key_column_drive;
   endproperty
   a_wires: assert property (p_wires) else $error("column pin level wrong");
   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rd_wait;
      hsel && hready && htrans == 2'h2 && hsize == 3'h2 && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_rd_one;
      !hreadyout |=> hreadyout;
   endproperty
   a_rd_one: assert property (p_rd_one) else $error("wait state too long");
   property p_settle;
      $rose(|key_column_drive) |=> $stable(key_column_drive) [*8];
   endproperty
   a_settle: assert property (p_settle) else $error("column not held to settle");
   property p_release;
      (|key_column_drive) && $changed(key_column_drive) |-> $past(key_column_drive) == 11'h000;
   endproperty
   a_release: assert property (p_release) else $error("no release between columns");
   property p_rst_req;
      $rose(keypad_reset_req) |-> $past(key_row_line, 2) != 8'hFF
         || $past(key_row_line, 3) != 8'hFF || $past(key_row_line, 4) != 8'hFF;
   endproperty
   a_rst_req: assert property (p_rst_req) else $error("reset request without low row");
endmodule
bind kms_key_matrix_scanner kms_scanner_checker u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .key_row_line(key_row_line), .key_column_drive(key_column_drive),
   .key_column_wires(key_column_wires), .keypad_reset_req(keypad_reset_req)
);

// >>> verif/kms_key_matrix_scanner_tb.sv
// Purpose: self-checking bench for the key matrix scanner
// Assumes: TICK_CYC shortened to 50, one frame near 1122 cycles
// Notes:   hready fed back from hreadyout, single slave
`timescale 1ns/100ps
module kms_key_matrix_scanner_tb
   import kms_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [7:0]  haddr, key_row_line;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [10:0] key_column_drive, key_column_wires, acc;
   logic        secondary_ext_irq, wake_req, keypad_reset_req;
   logic [87:0] keys_down, k8;
   int          num_errors, samples_checked;
   always #5 hclk = ~hclk;
   kms_key_matrix_scanner #(.TICK_CYC(50)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .key_row_line(key_row_line), .key_column_drive(key_column_drive),
      .key_column_wires(key_column_wires), .secondary_ext_irq(secondary_ext_irq),
      .wake_req(wake_req), .keypad_reset_req(keypad_reset_req));
   kms_matrix_model u_mat (.key_column_drive(key_column_drive),
      .key_row_line(key_row_line), .keys_down(keys_down));
   task automatic give_verdict;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait; sel 0 hreadyout, 1 wake, 2 reset request, 3 last column driven
   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      @(posedge hclk);
      while ((sel == 0 ? hreadyout : sel == 1 ? wake_req :
              sel == 2 ? keypad_reset_req : key_column_drive[10]) !== 1'b1) begin
         n++;
         if (n > lim) begin
            num_errors++;
            give_verdict;
         end
         @(posedge hclk);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr  <= a;
      wait_hi(0, 20);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_hi(0, 20);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic wait_st(input int b);
      int n;
      n = 0;
      xfer(1'b0, OFS_STATUS, 32'h0);
      while (rd[b] !== 1'b1) begin
         n++;
         if (n > 80) begin
            num_errors++;
            give_verdict;
         end
         repeat (100) @(posedge hclk);
         xfer(1'b0, OFS_STATUS, 32'h0);
      end
   endtask
   task automatic t_regs;
      chk({21'h0, key_column_wires}, 32'h7FF);
      rdc(OFS_TIMING, 32'h201);
      rdc(OFS_COUNT, 32'h0);
      xfer(1'b1, OFS_TIMING, 32'h5AA5);
      rdc(OFS_TIMING, 32'h5AA5);
      xfer(1'b1, OFS_TIMING, 32'h201);
      xfer(1'b1, OFS_STATUS, 32'h7);
      xfer(1'b1, 8'h18, 32'hFFFF);
      rdc(8'h18, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      xfer(1'b1, OFS_ENABLE, 32'h7);
      rdc(OFS_ENABLE, 32'h7);
   endtask
   task automatic t_scan;
      xfer(1'b1, OFS_CTRL, 32'h1);
      acc = 11'h0;
      repeat (1200) begin
         @(posedge hclk);
         acc = acc | key_column_drive;
      end
      chk({21'h0, acc}, 32'h7FF);
   endtask
   task automatic t_press(input logic [87:0] k, input logic [31:0] cnt);
      keys_down <= k;
      wait_st(ST_PRESS);
      // keys in other columns flip up to one frame after the first
      repeat (1200) @(posedge hclk);
      chk({31'h0, secondary_ext_irq}, 32'h1);
      rdc(OFS_KEYS0, k[31:0]);
      rdc(OFS_KEYS0 + 8'h04, k[63:32]);
      rdc(OFS_KEYS0 + 8'h08, {8'h0, k[87:64]});
      rdc(OFS_COUNT, cnt);
      xfer(1'b1, OFS_ENABLE, 32'h0);
      repeat (2) @(posedge hclk);
      chk({31'h0, secondary_ext_irq}, 32'h0);
      xfer(1'b1, OFS_ENABLE, 32'h7);
      xfer(1'b1, OFS_CLEAR, 32'h7);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rd[ST_PRESS]}, 32'h0);
      keys_down <= 88'h0;
      wait_st(ST_RELEASE);
      repeat (1200) @(posedge hclk);
      rdc(OFS_COUNT, 32'h0);
      xfer(1'b1, OFS_CLEAR, 32'h7);
   endtask
   task automatic t_glitch;
      // column 0 follows the last one: exactly one sample sees the key
      wait_hi(3, 1200);
      keys_down <= 88'h1;
      repeat (300) @(posedge hclk);
      keys_down <= 88'h0;
      repeat (4000) @(posedge hclk);
      rdc(OFS_STATUS, 32'h0);
   endtask
   task automatic t_power;
      xfer(1'b1, OFS_CTRL, 32'h13);
      keys_down <= 88'h200;
      wait_hi(1, 5000);
      xfer(1'b1, OFS_CTRL, 32'h09);
      repeat (1500) @(posedge hclk);
      chk({31'h0, keypad_reset_req}, 32'h0);
      chk({31'h0, wake_req}, 32'h0);
      xfer(1'b1, OFS_CTRL, 32'h0D);
      wait_hi(2, 1500);
      keys_down <= 88'h0;
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, haddr, htrans, hwdata} = '0;
      hsize = HSIZE_WORD;
      keys_down = 88'h0;
      num_errors = 0;
      samples_checked = 0;
      k8 = 88'h0;
      for (int r = 0; r < 7; r++) begin
         k8[r*9] = 1'b1;
      end
      k8[87] = 1'b1;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_scan;
      t_press({1'b1, 86'h0, 1'b1}, 32'h2);
      t_press(k8, 32'h8);
      t_glitch;
      t_power;
      give_verdict;
   end
endmodule

// >>> verif/kms_matrix_model.sv
// Purpose: passive key switch matrix at the scanner pins
// Assumes: key index col*8+row
// Notes:   ghost paths not modelled; keep keys in distinct rows and cols
`timescale 1ns/100ps
module kms_matrix_model (
   // scanner side
   input  wire logic [10:0] key_column_drive,
   output logic      [7:0]  key_row_line,
   // bench side
   input  wire logic [87:0] keys_down
);
   always_comb begin
      key_row_line = 8'hFF; // released rows sit at the pull-up
      for (int c = 0; c < 11; c++) begin
         for (int r = 0; r < 8; r++) begin
            if (key_column_drive[c] && keys_down[c*8+r]) begin
               key_row_line[r] = 1'b0; // closed key shorts row to low column
            end
         end
      end
   end
endmodule
